// *** verilog/irtmc_ctrl.sv ***
// host-side controller for the infrared transceiver: mode sequencing and data pins
`timescale 1ns/1ps
`default_nettype none
// Contract
// - static mode level low selects low, high selects high bandwidth
// - use low bandwidth up to 115.2 kbit/s, high bandwidth above
// - high mode: shutdown high, data high, 200 ns, shutdown low, hold 200 ns
// - low mode: shutdown high, data low, 200 ns, shutdown low, hold 200 ns
// - mode pin floats in dynamic programming; device may drive indicator
module irtmc_ctrl
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic mode_req_valid,
   input wire logic mode_req_high,
   input wire logic use_static_mode,
   output logic mode_busy,
   output logic mode_current,
   input wire logic tx_valid,
   input wire logic tx_bit,
   output logic tx_ready,
   output logic rx_valid,
   output logic rx_bit,
   input wire logic rx_ready,
   input wire logic enable,
   output logic tx_data,
   output logic shutdown_in,
   input wire logic rx_pin,
   output logic mode_pin_o,
   output logic mode_pin_oe_n,
   input wire logic mode_pin_i
);
   import irtmc_pkg::*;

   // ------------------------------------------------
   // input synchronisers and transmit history
   // ------------------------------------------------
   logic rx_meta;
   logic rx_sync;
   logic rx_prev;
   logic mode_meta;
   logic mode_sync;
   logic [2:0] tx_hist;

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
         mode_meta <= 1'b0;
         mode_sync <= 1'b0;
         tx_hist <= 3'h0;
      end
      else
      begin
         rx_meta <= rx_pin;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
         mode_meta <= mode_pin_i;
         mode_sync <= mode_meta;
         tx_hist <= {tx_hist[1:0], tx_data};
      end
   end

   // ------------------------------------------------
   // mode sequencer
   // ------------------------------------------------
   irtmc_state_e state;
   logic [cnt_width-1:0] cnt;
   logic target;
   logic mode;
   logic tx_out_valid;
   logic tx_out_bit;

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         state <= irtmc_idle;
         cnt <= '0;
         target <= reset_mode;
         mode <= reset_mode;
      end
      else
      begin
         unique case (state)
            irtmc_idle:
            begin
               // sequence only when no word is in flight
               if (mode_req_valid && !use_static_mode && !tx_data && !tx_out_valid)
               begin
                  target <= mode_req_high;
                  state <= irtmc_sd_high;
               end
            end
            irtmc_sd_high:
            begin
               cnt <= cnt_width'(setup_cycles + 1); // data rises a cycle after shutdown
               state <= irtmc_setup;
            end
            irtmc_setup:
            begin
               if (cnt == cnt_width'(1))
               begin
                  cnt <= cnt_width'(hold_cycles);
                  mode <= target;
                  state <= irtmc_hold;
               end
               else
               begin
                  cnt <= cnt - 1'b1;
               end
            end
            irtmc_hold:
            begin
               if (cnt == cnt_width'(1))
               begin
                  cnt <= cnt_width'(restart_cycles);
                  state <= irtmc_restart;
               end
               else
               begin
                  cnt <= cnt - 1'b1;
               end
            end
            irtmc_restart:
            begin
               if (cnt == cnt_width'(1))
               begin
                  state <= irtmc_idle;
               end
               else
               begin
                  cnt <= cnt - 1'b1;
               end
            end
            default:
            begin
               state <= irtmc_idle;
            end
         endcase
         if (use_static_mode)
         begin
            mode <= mode_req_high;
         end
      end
   end

   // ------------------------------------------------
   // pins
   // ------------------------------------------------
   logic tx_take;
   logic [cnt_width-1:0] pulse_cnt;

   assign tx_take = (state == irtmc_idle) && !shutdown_in && tx_out_valid;

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         shutdown_in <= reset_shutdown;
         tx_data <= 1'b0;
         pulse_cnt <= '0;
         mode_pin_o <= 1'b0;
         mode_pin_oe_n <= 1'b1;
         mode_busy <= 1'b0;
         mode_current <= reset_mode;
      end
      else
      begin
         mode_busy <= (state != irtmc_idle);
         mode_current <= mode;
         mode_pin_o <= mode_req_high;
         mode_pin_oe_n <= !use_static_mode;
         unique case (state)
            irtmc_sd_high:
            begin
               shutdown_in <= 1'b1;
               tx_data <= 1'b0;
            end
            irtmc_setup:
            begin
               tx_data <= target;
               if (cnt == cnt_width'(1))
               begin
                  shutdown_in <= 1'b0;
               end
            end
            irtmc_hold:
            begin
               if (cnt == cnt_width'(1))
               begin
                  tx_data <= 1'b0;
               end
            end
            irtmc_restart:
            begin
               tx_data <= 1'b0;
            end
            irtmc_idle:
            begin
               shutdown_in <= !enable;
               if (tx_take)
               begin
                  // stay under the emitter cut-off
                  if (tx_out_bit && pulse_cnt < cnt_width'(max_pulse_cycles - 1))
                  begin
                     tx_data <= 1'b1;
                     pulse_cnt <= pulse_cnt + 1'b1;
                  end
                  else
                  begin
                     tx_data <= 1'b0;
                     pulse_cnt <= '0;
                  end
               end
               else
               begin
                  tx_data <= 1'b0;
                  pulse_cnt <= '0;
               end
            end
            default:
            begin
               tx_data <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------
   // transmit buffer
   // ------------------------------------------------
   irtmc_buf #(.width(1), .depth(buf_depth)) tx_buf
   (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .in_data(tx_bit),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(tx_out_bit),
      .out_valid(tx_out_valid),
      .out_ready(tx_take)
   );

   // ------------------------------------------------
   // receive: one bit per received pulse out of shutdown
   // ------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         rx_valid <= 1'b0;
         rx_bit <= 1'b0;
      end
      else if (rx_valid && !rx_ready)
      begin
         rx_valid <= 1'b1;
      end
      else
      begin
         // falling edge of active-low receive only when awake and idle
         rx_valid <= (state == irtmc_idle) && !shutdown_in && rx_prev && !rx_sync && !tx_data
            && (tx_hist == 3'h0);
         rx_bit <= 1'b1;
      end
   end
endmodule : irtmc_ctrl
`default_nettype wire

// *** common/irtmc_pkg.sv ***
// constants and types of the infrared transceiver mode controller
package irtmc_pkg;
   localparam int unsigned clk_period_ns = 100;
   localparam int unsigned setup_time_ns = 200;
   localparam int unsigned hold_time_ns = 200;
   localparam int unsigned max_pulse_us = 80;
   localparam int unsigned restart_time_us = 500;
   localparam int unsigned setup_cycles = (setup_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int unsigned hold_cycles = (hold_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int unsigned max_pulse_cycles = (max_pulse_us * 1000) / clk_period_ns;
   localparam int unsigned restart_cycles = (restart_time_us * 1000 + clk_period_ns - 1) / clk_period_ns;
   localparam int unsigned cnt_width = 13;
   localparam logic reset_mode = 1'b0;
   localparam logic reset_shutdown = 1'b1;
   localparam int unsigned buf_depth = 2;

   typedef enum logic [2:0]
   {
      irtmc_idle = 3'b000,
      irtmc_sd_high = 3'b001,
      irtmc_setup = 3'b010,
      irtmc_hold = 3'b011,
      irtmc_restart = 3'b100
   } irtmc_state_e;
endpackage : irtmc_pkg

// *** verilog/irtmc_buf.sv ***
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module irtmc_buf
#(
   parameter int unsigned width = 1,
   parameter int unsigned depth = 2
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [width-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [width-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [width-1:0] mem [depth];
   logic [$clog2(depth):0] count;
   logic [$clog2(depth)-1:0] wr_ptr;
   logic [$clog2(depth)-1:0] rd_ptr;
   logic push;
   logic pop;

   assign in_ready = (count != ($clog2(depth)+1)'(depth));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         count <= '0;
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= ($clog2(depth))'((wr_ptr + 1'b1) % depth);
         end
         if (pop)
         begin
            rd_ptr <= ($clog2(depth))'((rd_ptr + 1'b1) % depth);
         end
         count <= ($clog2(depth)+1)'(count + push - pop);
      end
   end
endmodule : irtmc_buf
`default_nettype wire

// *** tb/irtmc_checker.sv ***
// port assertions of the infrared transceiver mode controller
`timescale 1ns/1ps
`default_nettype none
module irtmc_checker
import irtmc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic mode_req_high,
   input wire logic use_static_mode,
   input wire logic mode_busy,
   input wire logic mode_current,
   input wire logic rx_valid,
   input wire logic rx_bit,
   input wire logic rx_ready,
   input wire logic tx_data,
   input wire logic shutdown_in,
   input wire logic rx_pin,
   input wire logic mode_pin_o,
   input wire logic mode_pin_oe_n
);
   logic [15:0] busy_cnt;
   logic [15:0] hi_cnt;
   // ----------------------------------------
   // run counters
   // ----------------------------------------
   always_ff @(posedge ref_clk)
      busy_cnt <= (reset_n && mode_busy) ? busy_cnt + 16'h0001 : 16'h0000;
   always_ff @(posedge ref_clk)
      hi_cnt <= (reset_n && tx_data) ? hi_cnt + 16'h0001 : 16'h0000;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_reset_vals:
      assert property (disable iff (1'b0) !reset_n |=> shutdown_in && !tx_data && mode_pin_oe_n && !mode_busy
         && !mode_current && !rx_valid) else $error("bad reset values");
   a_seq_timing:
      assert property ($fell(shutdown_in) && mode_busy |-> $past(shutdown_in, 3) && $past(tx_data, 2) == tx_data
         && $stable(tx_data) ##1 $stable(tx_data)) else $error("setup or hold too short");
   a_mode_latch:
      assert property ($fell(shutdown_in) && mode_busy |=> mode_current == $past(tx_data))
         else $error("mode not latched");
   a_restart_wait:
      assert property ($fell(mode_busy) |-> busy_cnt >= restart_cycles) else $error("restart too short");
   a_pulse_limit:
      assert property (hi_cnt <= max_pulse_cycles) else $error("pulse too long");
   a_static_drive:
      assert property (use_static_mode [*2] |-> !mode_pin_oe_n && mode_pin_o == $past(mode_req_high))
         else $error("static level wrong");
   a_dyn_float:
      assert property (!use_static_mode [*2] |-> mode_pin_oe_n) else $error("mode pin driven");
   a_rx_detect:
      assert property ($fell(rx_pin) && !shutdown_in && !tx_data && !mode_busy |-> ##[3:5] rx_valid)
         else $error("pulse missed");
   a_rx_hold:
      assert property (rx_valid && !rx_ready |=> rx_valid && rx_bit) else $error("rx dropped");
endmodule : irtmc_checker
bind irtmc_ctrl irtmc_checker i_irtmc_checker (.*);
`default_nettype wire

// *** tb/irtmc_dev.sv ***
// behavioural transceiver facing the controller
`timescale 1ns/1ps
`default_nettype none
module irtmc_dev
(
   input wire logic tx_data,
   input wire logic shutdown_in,
   input wire logic mode_pin_o,
   input wire logic mode_pin_oe_n,
   input wire logic light,
   output logic rx_pin,
   output logic mode_pin_i,
   output logic bw
);
   logic latched = 1'b0;
   logic emit;
   always @(negedge shutdown_in)
      latched = tx_data;
   assign bw = mode_pin_oe_n ? latched : mode_pin_o;
   assign mode_pin_i = bw;
   assign emit = tx_data && !shutdown_in;
   assign rx_pin = shutdown_in || !(emit || light);
endmodule : irtmc_dev
`default_nettype wire

// *** tb/tb_top.sv ***
// testbench of the infrared transceiver mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import irtmc_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic mode_req_valid = 1'b0;
   logic mode_req_high = 1'b0;
   logic use_static_mode = 1'b0;
   logic tx_valid = 1'b0;
   logic tx_bit = 1'b0;
   logic rx_ready = 1'b1;
   logic enable = 1'b0;
   logic light = 1'b0;
   logic mode_busy, mode_current, tx_ready, rx_valid, rx_bit, tx_data, shutdown_in;
   logic rx_pin, mode_pin_o, mode_pin_oe_n, mode_pin_i, bw, busy_d, em;
   logic rq[$];
   logic mq[$];
   int error_cnt = 0;
   int num_checks = 0;
   int pulse_len = 0;
   irtmc_ctrl i_irtmc_ctrl (.*);
   irtmc_dev i_irtmc_dev (.*);
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      rx_ready <= $urandom % 4 != 0;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic e, input logic g);
      num_checks++;
      if (e !== g)
      begin
         error_cnt++;
         $display("mismatch %s exp %b got %b", nm, e, g);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   task automatic set_mode(input logic m);
      int n;
      n = 0;
      mq.push_back(m);
      mode_req_high <= m;
      mode_req_valid <= 1'b1;
      cyc(1);
      mode_req_valid <= 1'b0;
      cyc(3);
      while (mode_busy !== 1'b0 && n < 6000)
      begin
         cyc(1);
         n++;
      end
      cyc(2);
   endtask : set_mode
   task automatic flash(input logic seen);
      if (seen)
         rq.push_back(1'b1);
      light <= 1'b1;
      cyc(2);
      light <= 1'b0;
      cyc(20);
   endtask : flash
   // ----------------------------------------
   // result monitor
   // ----------------------------------------
   always @(posedge ref_clk)
   begin
      busy_d <= mode_busy;
      if (reset_n === 1'b1 && rx_valid === 1'b1 && rx_ready === 1'b1)
         chk("rx_bit", rq.size() > 0 ? rq.pop_front() : 1'bx, rx_bit);
      if (busy_d === 1'b1 && mode_busy === 1'b0)
      begin
         em = mq.size() > 0 ? mq.pop_front() : 1'bx;
         chk("mode_current", em, mode_current);
         chk("bw", em, bw);
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(30786));
      cyc(3);
      reset_n <= 1'b1;
      chk("shutdown_in", 1'b1, shutdown_in);
      chk("bw", 1'b0, bw);
      chk("rx_pin", 1'b1, rx_pin);
      enable <= 1'b1;
      cyc(10);
      flash(1'b1);
      set_mode($urandom % 2 == 1);
      set_mode(1'b1);
      flash(1'b1);
      set_mode(1'b0);
      enable <= 1'b0;
      cyc(5);
      flash(1'b0);
      tx_valid <= 1'b1;
      tx_bit <= 1'b1;
      cyc(4);
      chk("tx_ready", 1'b0, tx_ready);
      chk("tx_data", 1'b0, tx_data);
      enable <= 1'b1;
      repeat (60)
      begin
         tx_bit <= $urandom % 2 == 1;
         tx_valid <= $urandom % 3 != 0;
         cyc(1);
      end
      tx_bit <= 1'b0;
      tx_valid <= 1'b1;
      cyc(5);
      tx_bit <= 1'b1;
      pulse_len = 0;
      while (tx_data !== 1'b1 && pulse_len < 10)
      begin
         cyc(1);
         pulse_len++;
      end
      pulse_len = 0;
      while (tx_data === 1'b1 && pulse_len < 1000)
      begin
         cyc(1);
         pulse_len++;
      end
      chk("pulse_len", 1'b1, pulse_len == max_pulse_cycles - 1);
      chk("tx_data", 1'b0, tx_data);
      tx_valid <= 1'b0;
      cyc(10);
      use_static_mode <= 1'b1;
      mode_req_high <= 1'b1;
      cyc(3);
      chk("bw", 1'b1, bw);
      chk("mode_current", 1'b1, mode_current);
      mode_req_valid <= 1'b1;
      mode_req_high <= 1'b0;
      cyc(3);
      chk("mode_busy", 1'b0, mode_busy);
      chk("bw", 1'b0, bw);
      mode_req_valid <= 1'b0;
      use_static_mode <= 1'b0;
      cyc(3);
      chk("mode_pin_oe_n", 1'b1, mode_pin_oe_n);
      chk("queues", 1'b0, rq.size() + mq.size() > 0);
      finish_test();
   end
   initial
   begin
      #5_000_000;
      error_cnt++;
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
